// [design/acrsc_ctrl.sv]
// Channel mode control: soft reset, shutdown, hard reset and clock gating.
// Assumes modulator_in is synchronous to mclk and rst_n merges pin and power-on reset.
//
// How it works
// RL1 - Soft reset bit holds channel output zero
// RL2 - Soft reset forces quantizer field to 0011
// RL3 - Channels reset independently, configuration left untouched
// RL4 - No data-ready while in soft reset
// RL5 - Valid codes once filter settles after reset
// RL6 - Phase kept, realigned to running frame counter
// RL7 - Partial soft reset keeps internal clock running
// RL8 - All in soft reset gates core clock
// RL9 - Input structure clocked during full soft reset
// RL10 - Hard reset returns every register to default
// RL11 - Hard reset clears data, quantizers, filters
// RL12 - Register port ignored during hard reset
// RL13 - Host holds reset low for minimum width
// RL14 - Leaving shutdown: first data-ready after settling
// RL15 - Host discards results during bias settling
// RL16 - Shutdown per channel, configuration left untouched
// RL17 - Shut channel reads zero, no data-ready
// RL18 - Shutdown exit keeps and realigns phase
// RL19 - Partial shutdown keeps internal clock running
// RL20 - All shut down gates input and core
//
// Chosen here: the address-and-strobe port and the placing of the registers.

`timescale 1ns/100ps

module acrsc_ctrl #(
	parameter int DEC_LEN = acrsc_pkg::DEC_LEN_DEF, // Clocks per frame
	parameter int SETTLE_FRAMES = acrsc_pkg::SETTLE_FRAMES_DEF, // Frames after wake, all but the last dropped
	parameter int BIAS_CYC = acrsc_pkg::BIAS_SETTLE_CYC // Bias settle count
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic ce,
	input wire acrsc_pkg::acrsc_bus_s bus,
	output logic [acrsc_pkg::DATA_W-1:0] rdata,
	input wire logic [acrsc_pkg::NUM_CH*acrsc_pkg::QW-1:0] modulator_in,
	output logic [acrsc_pkg::NUM_CH-1:0] drdy,
	output logic core_clk_en,
	output logic input_clk_en
);
	import acrsc_pkg::*;

	// ************************************************************
	// Elaboration checks
	// ************************************************************
	if (DEC_LEN < 2 || DEC_LEN > (1 << PH_W)) begin : g_bad_len
		$error("DEC_LEN must lie in 2..256");
	end
	if (SETTLE_FRAMES < 1 || SETTLE_FRAMES > 15) begin : g_bad_settle
		$error("SETTLE_FRAMES must lie in 1..15");
	end
	if (BIAS_CYC < 1) begin : g_bad_bias
		$error("BIAS_CYC must be at least 1");
	end

	localparam int BIAS_W = $clog2(BIAS_CYC + 1); // Bias counter width
	localparam logic [PH_W-1:0] FRAME_LAST = PH_W'(DEC_LEN - 1);
	localparam logic [3:0] SETTLE_LAST = 4'(SETTLE_FRAMES - 1);
	localparam logic [BIAS_W-1:0] BIAS_LOAD = BIAS_W'(BIAS_CYC);

	// ************************************************************
	// Helpers
	// ************************************************************
	// Phase byte of one channel
	function automatic logic [PH_W-1:0] phase_of(input logic [DATA_W-1:0] ph, input int ch);
		return ph[ch*PH_W +: PH_W];
	endfunction : phase_of

	// Number of comparators that fired
	function automatic logic [2:0] thermo_count(input logic [QW-1:0] t);
		return 3'(t[0]) + 3'(t[1]) + 3'(t[2]) + 3'(t[3]);
	endfunction : thermo_count

	// ************************************************************
	// Configuration and shared state
	// ************************************************************
	logic [NUM_CH-1:0] srst; // Soft reset bits
	logic [NUM_CH-1:0] sd; // Shutdown bits
	logic [DATA_W-1:0] phase; // Phase delay bytes
	logic [PH_W-1:0] frame_cnt; // Common frame position
	logic [NUM_CH-1:0] chan_norm; // Channel in normal operation
	logic core_run; // Core clock actually ticking
	logic [NUM_CH-1:0] drdy_w; // Collected data-ready flops
	logic [NUM_CH*QW-1:0] quant_w; // Collected quantizer fields
	logic [NUM_CH-1:0] running_w; // Channels in run state
	logic [NUM_CH-1:0] bias_busy_w; // Channels with bias settling
	logic [OUT_W-1:0] data_w [NUM_CH]; // Collected results

	assign chan_norm = ~srst & ~sd;
	// Core needs a clock only while some channel converts
	assign core_clk_en = |chan_norm; // RL8 RL20
	// Inputs stay biased unless every channel is off
	assign input_clk_en = ~(&sd); // RL9 RL20
	assign core_run = ce & core_clk_en;
	assign drdy = drdy_w;

	// ************************************************************
	// Register writes
	// ************************************************************
	// Each field has its own decode, so a write never disturbs another
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			srst <= SRST_INIT; // RL10
			sd <= SHDN_INIT;
			phase <= PHASE_INIT;
		end else if (ce && bus.wr) begin
			if (bus.addr == REG_CFG0) begin
				srst <= bus.wdata[CH_FIELD_LSB +: NUM_CH]; // RL1 RL3
			end else if (bus.addr == REG_CFG1) begin
				sd <= bus.wdata[CH_FIELD_LSB +: NUM_CH]; // RL16
			end else if (bus.addr == REG_PHASE) begin
				phase <= bus.wdata;
			end
		end
	end

	// ************************************************************
	// Frame counter
	// ************************************************************
	// Frozen while the core clock is gated, free-running otherwise
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			frame_cnt <= '0; // RL11
		end else if (core_run) begin // RL7 RL19
			if (frame_cnt == FRAME_LAST) begin
				frame_cnt <= '0;
			end else begin
				frame_cnt <= frame_cnt + 8'h01;
			end
		end
	end

	// ************************************************************
	// Per-channel logic
	// ************************************************************
	for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
		acrsc_ch_e st; // Channel mode
		acrsc_ch_e next_st; // Next mode
		logic [3:0] settle_cnt; // Frames seen while settling
		logic [OUT_W-1:0] acc; // Running filter sum
		logic [OUT_W-1:0] dout; // Output buffer
		logic [QW-1:0] quant; // Quantizer field
		logic dr; // Data-ready flop
		logic [BIAS_W-1:0] bias_cnt; // Bias settling countdown
		logic boundary; // Frame ends for this channel
		logic last_settle; // Final settling frame
		logic deliver; // Result is handed out now

		// Phase offset picks which counter value closes the frame
		assign boundary = core_run && (frame_cnt == phase_of(phase, g)); // RL6 RL18
		assign last_settle = (st == CH_SETTLE) && (settle_cnt == SETTLE_LAST);
		// Config gate catches the cycle before the mode catches up
		assign deliver = boundary && chan_norm[g] && (st == CH_RUN || last_settle); // RL4 RL17

		// Mode selection, shutdown over soft reset
		always_comb begin
			next_st = st;
			case (st)
				CH_OFF: begin
					if (sd[g]) begin
						next_st = CH_OFF;
					end else if (srst[g]) begin
						next_st = CH_RESET;
					end else begin
						next_st = CH_SETTLE; // RL14
					end
				end
				CH_RESET: begin
					if (sd[g]) begin
						next_st = CH_OFF;
					end else if (!srst[g]) begin
						next_st = CH_SETTLE; // RL5
					end
				end
				CH_SETTLE: begin
					if (sd[g]) begin
						next_st = CH_OFF;
					end else if (srst[g]) begin
						next_st = CH_RESET;
					end else if (last_settle && boundary) begin
						next_st = CH_RUN;
					end
				end
				CH_RUN: begin
					if (sd[g]) begin
						next_st = CH_OFF;
					end else if (srst[g]) begin
						next_st = CH_RESET;
					end
				end
				default: begin
					next_st = CH_OFF;
				end
			endcase
		end

		// Mode register
		always_ff @(posedge mclk) begin
			if (!rst_n) begin
				st <= CH_SETTLE; // RL10
			end else if (ce) begin
				st <= next_st;
			end
		end

		// Settling frame count
		always_ff @(posedge mclk) begin
			if (!rst_n) begin
				settle_cnt <= '0;
			end else if (ce) begin
				if (st != CH_SETTLE) begin
					settle_cnt <= '0;
				end else if (boundary) begin
					settle_cnt <= settle_cnt + 4'h1; // RL5 RL14
				end
			end
		end

		// Quantizer field; also forced while shut down
		always_ff @(posedge mclk) begin
			if (!rst_n) begin
				quant <= QUANT_RST; // RL11
			end else if (ce) begin
				if (srst[g] || sd[g]) begin
					quant <= QUANT_RST; // RL2
				end else begin
					quant <= modulator_in[g*QW +: QW];
				end
			end
		end

		// Filter integrates while the core runs, soft reset included; cleared to zero when off
		always_ff @(posedge mclk) begin
			if (!rst_n) begin
				acc <= '0; // RL11
			end else if (ce) begin
				if (st == CH_OFF) begin
					acc <= '0;
				end else if (boundary) begin
					acc <= OUT_W'(thermo_count(quant));
				end else if (core_run) begin
					acc <= acc + OUT_W'(thermo_count(quant));
				end
			end
		end

		// Output buffer, zero while held or off
		always_ff @(posedge mclk) begin
			if (!rst_n) begin
				dout <= '0; // RL11
			end else if (ce) begin
				if (st == CH_OFF || st == CH_RESET) begin
					dout <= '0; // RL1 RL17
				end else if (deliver) begin
					dout <= acc;
				end
			end
		end

		// One-cycle data-ready pulse; held, not repeated, while ce is low
		always_ff @(posedge mclk) begin
			if (!rst_n) begin
				dr <= 1'b0;
			end else if (ce) begin
				dr <= deliver; // RL4 RL17
			end
		end

		// Countdown is status only; the host must still discard early results
		always_ff @(posedge mclk) begin
			if (!rst_n) begin
				bias_cnt <= '0;
			end else if (ce) begin
				if (sd[g]) begin
					bias_cnt <= BIAS_LOAD; // RL15
				end else if (bias_cnt != '0) begin
					bias_cnt <= bias_cnt - 1'b1;
				end
			end
		end

		assign drdy_w[g] = dr;
		assign quant_w[g*QW +: QW] = quant;
		assign data_w[g] = dout;
		assign running_w[g] = (st == CH_RUN);
		assign bias_busy_w[g] = (bias_cnt != '0);

		// ************************************************************
		// Checks for this channel
		// ************************************************************
		property p_quant_reset;
			@(posedge mclk) disable iff (!rst_n)
			(ce && srst[g]) |=> (quant == QUANT_RST);
		endproperty
		a_quant_reset: assert property (p_quant_reset) else $error("quantizer not forced in soft reset"); // RL2

		property p_data_zero;
			@(posedge mclk) disable iff (!rst_n)
			(ce && (st == CH_OFF || st == CH_RESET)) |=> (dout == '0);
		endproperty
		a_data_zero: assert property (p_data_zero) else $error("result not zero while held"); // RL1 RL17

		property p_no_drdy_held;
			@(posedge mclk) disable iff (!rst_n)
			(dr && $past(ce)) |-> ($past(st) inside {CH_SETTLE, CH_RUN} && !$past(srst[g]) && !$past(sd[g]));
		endproperty
		a_no_drdy_held: assert property (p_no_drdy_held) else $error("data-ready from held channel"); // RL4 RL17

		property p_phase_align;
			@(posedge mclk) disable iff (!rst_n)
			(dr && $past(ce)) |-> $past(frame_cnt == phase_of(phase, g));
		endproperty
		a_phase_align: assert property (p_phase_align) else $error("data-ready off its phase"); // RL6 RL18

		property p_settle_first;
			@(posedge mclk) disable iff (!rst_n)
			(dr && $past(ce)) |-> ($past(st) == CH_RUN || $past(settle_cnt) == SETTLE_LAST);
		endproperty
		a_settle_first: assert property (p_settle_first) else $error("data-ready before settling"); // RL5 RL14

		c_wake_drdy: cover property (@(posedge mclk) disable iff (!rst_n)
			$fell(sd[g]) ##[1:1000] dr);
	end

	// ************************************************************
	// Register reads
	// ************************************************************
	// Data stand one cycle after the strobe, zero otherwise
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			rdata <= '0; // RL12
		end else if (ce) begin
			if (!bus.rd) begin
				rdata <= '0;
			end else if (bus.addr == REG_CFG0) begin
				rdata <= DATA_W'(srst);
			end else if (bus.addr == REG_CFG1) begin
				rdata <= DATA_W'(sd);
			end else if (bus.addr == REG_PHASE) begin
				rdata <= phase;
			end else if (bus.addr == REG_MODULATOR) begin
				rdata <= DATA_W'(quant_w);
			end else if (bus.addr[3:2] == REG_DATA0[3:2]) begin
				rdata <= DATA_W'(data_w[bus.addr[1:0]]);
			end else if (bus.addr == REG_STATUS) begin
				rdata <= {22'h000000, input_clk_en, core_clk_en, bias_busy_w, running_w};
			end else begin
				rdata <= '0;
			end
		end
	end

	// ************************************************************
	// Module-wide checks
	// ************************************************************
	property p_hard_reset;
		@(posedge mclk) disable iff (1'b0)
		!rst_n |=> (rdata == '0 && drdy == '0 && quant_w == {NUM_CH{QUANT_RST}} && srst == SRST_INIT);
	endproperty
	a_hard_reset: assert property (p_hard_reset) else $error("state not defaulted by hard reset"); // RL10 RL11 RL12

	property p_core_frozen;
		@(posedge mclk) disable iff (!rst_n)
		!core_clk_en |=> (frame_cnt == $past(frame_cnt));
	endproperty
	a_core_frozen: assert property (p_core_frozen) else $error("core counter moved while gated"); // RL8

	property p_clock_kept;
		@(posedge mclk) disable iff (!rst_n)
		(ce && rst_n && (|chan_norm)) |=> (frame_cnt != $past(frame_cnt));
	endproperty
	a_clock_kept: assert property (p_clock_kept) else $error("core clock stopped with a channel active"); // RL7 RL19

	property p_input_gate;
		@(posedge mclk) disable iff (!rst_n)
		(&srst && !(&sd)) |-> (input_clk_en && !core_clk_en);
	endproperty
	a_input_gate: assert property (p_input_gate) else $error("input clock lost in full soft reset"); // RL9

	property p_all_off;
		@(posedge mclk) disable iff (!rst_n)
		(&sd) |-> (!input_clk_en && !core_clk_en && rdata[ST_INPUT_BIT] == 1'b0);
	endproperty
	a_all_off: assert property (p_all_off) else $error("clocks run with all channels off"); // RL20

	property p_cfg_hold;
		@(posedge mclk) disable iff (!rst_n)
		(bus.wr && bus.addr != REG_CFG0 && bus.addr != REG_CFG1) |=> (srst == $past(srst) && sd == $past(sd));
	endproperty
	a_cfg_hold: assert property (p_cfg_hold) else $error("mode bits changed by other write"); // RL3 RL16

	c_all_reset: cover property (@(posedge mclk) disable iff (!rst_n) (&srst) ##1 !(&srst));
	c_all_drdy: cover property (@(posedge mclk) disable iff (!rst_n) (&running_w) ##[1:300] drdy[3]);
	c_shut_all: cover property (@(posedge mclk) disable iff (!rst_n) (&sd) ##1 !(&sd));

endmodule : acrsc_ctrl

// [design/acrsc_pkg.sv]
// Shared constants and types for the four-channel reset and shutdown controller.
// Assumes a single 25 MHz master clock and word-indexed register addresses.

package acrsc_pkg;

	// ************************************************************
	// Sizes
	// ************************************************************
	localparam int NUM_CH = 4; // Converter channels
	localparam int QW = 4; // Flash quantizer width, thermometer coded
	localparam int DATA_W = 32; // Register data width
	localparam int ADDR_W = 4; // Register index width
	localparam int PH_W = 8; // Phase field width per channel
	localparam int OUT_W = 24; // Conversion result width

	// ************************************************************
	// Register indices
	// ************************************************************
	localparam logic [ADDR_W-1:0] REG_CFG0 = 4'h0; // Soft reset field
	localparam logic [ADDR_W-1:0] REG_CFG1 = 4'h1; // Second configuration register, shutdown field
	localparam logic [ADDR_W-1:0] REG_PHASE = 4'h2; // Phase delay, one byte per channel
	localparam logic [ADDR_W-1:0] REG_MODULATOR = 4'h3; // Modulator output register
	localparam logic [ADDR_W-1:0] REG_DATA0 = 4'h4; // Channel results, 4 to 7
	localparam logic [ADDR_W-1:0] REG_STATUS = 4'h8; // Run, bias and clock status

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int CH_FIELD_LSB = 0; // Per-channel mode fields start here
	localparam int ST_RUN_LSB = 0; // Channels delivering data
	localparam int ST_BIAS_LSB = 4; // Channels still settling bias
	localparam int ST_CORE_BIT = 8; // Digital core clock running
	localparam int ST_INPUT_BIT = 9; // Input structure clock running

	// ************************************************************
	// Reset values
	// ************************************************************
	localparam logic [QW-1:0] QUANT_RST = 4'h3; // Quantizer reset pattern
	localparam logic [NUM_CH-1:0] SRST_INIT = 4'h0;
	localparam logic [NUM_CH-1:0] SHDN_INIT = 4'h0;
	localparam logic [DATA_W-1:0] PHASE_INIT = 32'h00000000;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int DEC_LEN_DEF = 64; // Clocks per decimation frame
	localparam int SETTLE_FRAMES_DEF = 3; // Frames the filter needs to settle
	localparam int BIAS_SETTLE_US = 1000; // Bias settling after shutdown, in us
	localparam int CLK_KHZ = 25000; // Master clock rate
	localparam int BIAS_SETTLE_CYC = (BIAS_SETTLE_US * CLK_KHZ + 999) / 1000;

	// ************************************************************
	// Types
	// ************************************************************
	typedef struct packed {
		logic [ADDR_W-1:0] addr; // Register index
		logic [DATA_W-1:0] wdata; // Write data
		logic wr; // Write strobe
		logic rd; // Read strobe
	} acrsc_bus_s;

	typedef enum logic [1:0] {
		CH_OFF = 2'b00, // Shut down
		CH_RESET = 2'b01, // Soft reset, converter running
		CH_SETTLE = 2'b10, // Filter settling, results discarded until the last frame
		CH_RUN = 2'b11 // Delivering results
	} acrsc_ch_e;

endpackage : acrsc_pkg

// [sim/acrsc_host_mdl.sv]
// Host-side model: supplies quantizer codes and counts data-ready pulses.
// Assumes drdy is a one-cycle pulse synchronous to mclk.
`timescale 1ns/100ps

module acrsc_host_mdl #(
	parameter logic [15:0] CODES = 16'h7f1f // Thermometer codes, ch3..ch0
) (
	input wire logic mclk,
	input wire logic clr,
	input wire logic [acrsc_pkg::NUM_CH-1:0] drdy,
	output logic [acrsc_pkg::NUM_CH*acrsc_pkg::QW-1:0] modulator_in,
	output logic [7:0] cnt [acrsc_pkg::NUM_CH],
	output logic [7:0] age0
);
	import acrsc_pkg::*;

	// ************************************************************
	// Pulse bookkeeping
	// ************************************************************
	// Constant codes keep the expected filter sums simple
	assign modulator_in = CODES;

	// Pulse counts, and cycles since the last channel 0 pulse
	always_ff @(posedge mclk) begin
		for (int i = 0; i < NUM_CH; i++) begin
			if (clr) begin
				cnt[i] <= 8'h00;
			end else if (drdy[i]) begin
				cnt[i] <= cnt[i] + 8'h01;
			end
		end
		age0 <= (clr || drdy[0]) ? 8'h00 : age0 + 8'h01;
	end

endmodule : acrsc_host_mdl

// [sim/tb_acrsc_ctrl.sv]
// Testbench for the channel mode controller: register tasks and scenarios.
// Assumes short counts: 8-clock frames, 3 settle frames, 20-cycle bias wait.
`timescale 1ns/100ps

module tb_acrsc_ctrl;
	import acrsc_pkg::*;

	// ************************************************************
	// Signals
	// ************************************************************
	localparam int D = 8; // Frame length
	localparam int S = 3; // Settle frames
	localparam int B = 20; // Bias cycles
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic ce = 1'b1;
	logic clr = 1'b1;
	acrsc_bus_s bus = '0;
	logic [DATA_W-1:0] rdata;
	logic [DATA_W-1:0] d; // Last read word
	logic [NUM_CH*QW-1:0] modulator_in;
	logic [NUM_CH-1:0] drdy;
	logic core_clk_en;
	logic input_clk_en;
	logic [7:0] cnt [NUM_CH];
	logic [7:0] age0;
	int err_count = 0;
	int tests_run = 0;
	int n;

	always #20 mclk = ~mclk;

	acrsc_ctrl #(.DEC_LEN(D), .SETTLE_FRAMES(S), .BIAS_CYC(B)) i_acrsc_ctrl (.mclk(mclk), .rst_n(rst_n), .ce(ce),
		.bus(bus), .rdata(rdata), .modulator_in(modulator_in), .drdy(drdy), .core_clk_en(core_clk_en),
		.input_clk_en(input_clk_en));
	acrsc_host_mdl i_acrsc_host_mdl (.mclk(mclk), .clr(clr), .drdy(drdy), .modulator_in(modulator_in),
		.cnt(cnt), .age0(age0));

	// ************************************************************
	// Tasks
	// ************************************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
		end
	endtask : chk

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : summarize

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
		@(posedge mclk);
		bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
		@(posedge mclk);
		bus.wr <= 1'b0;
		#1;
	endtask : wr

	// Read word lands in d, sampled in the one cycle it stands
	task automatic rd(input logic [ADDR_W-1:0] a);
		@(posedge mclk);
		bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge mclk);
		bus.rd <= 1'b0;
		#1;
		d = rdata;
	endtask : rd

	task automatic cycles(input int k);
		repeat (k) @(posedge mclk);
		#1;
	endtask : cycles

	task automatic cnt_clear();
		@(posedge mclk);
		clr <= 1'b1;
		@(posedge mclk);
		clr <= 1'b0;
		#1;
	endtask : cnt_clear

	// Bounded wait for one channel's pulse; a missed pulse ends the run
	task automatic wait_dr(input int ch, output int c);
		for (c = 1; c <= 200; c++) begin
			@(posedge mclk);
			#1;
			if (drdy[ch] === 1'b1) begin
				return;
			end
		end
		chk(32'h0, 32'h1, "data-ready timeout");
		summarize();
	endtask : wait_dr

	// ************************************************************
	// Scenarios
	// ************************************************************
	initial begin
		repeat (16) @(posedge mclk);
		rst_n <= 1'b1;
		clr <= 1'b0;
		// Defaults after reset
		rd(REG_CFG0); chk(d, 32'h0, "cfg0 reset");
		// Quantizers leave their reset pattern on the first edge after release
		rd(REG_MODULATOR); chk(d, 32'h7f1f, "quantizers live after reset");
		rd(REG_DATA0); chk(d, 32'h0, "data0 reset");
		rd(REG_STATUS); chk(d[9:4], 6'h30, "status reset");
		rd(4'h9); chk(d, 32'h0, "unmapped read");
		$display("test defaults done");
		// Steady running: one pulse a frame, sums of the codes
		cycles(60);
		cnt_clear();
		cycles(5 * D);
		chk(32'(cnt[3]), 32'h5, "pulses per frame");
		rd(REG_DATA0 + 4'h3); chk(d, 32'h18, "ch3 sum");
		$display("test run done");
		// Soft reset of ch1 alone, ch3 phase moved meanwhile
		wr(REG_CFG0, 32'h2);
		cycles(3);
		rd(REG_MODULATOR); chk(d[7:4], 4'h3, "ch1 quantizer");
		rd(REG_DATA0 + 4'h1); chk(d, 32'h0, "ch1 data");
		rd(REG_CFG1); chk(d, 32'h0, "cfg1 kept");
		chk(32'(core_clk_en), 32'h1, "core clock");
		wr(REG_PHASE, 32'h03000000);
		cnt_clear();
		cycles(5 * D);
		chk(32'(cnt[1]), 32'h0, "ch1 silent");
		chk(32'(cnt[0]), 32'h5, "ch0 running");
		wr(REG_CFG0, 32'h0);
		wait_dr(1, n);
		chk(32'(n >= 2 * D && n <= 3 * D + 2), 32'h1, "ch1 settle time");
		chk(32'(drdy[0]), 32'h1, "ch1 aligned");
		wait_dr(3, n);
		chk(32'(age0), 32'h2, "ch3 phase offset");
		$display("test soft reset done");
		// Shutdown of ch2 alone
		wr(REG_CFG1, 32'h4);
		cycles(3);
		rd(REG_DATA0 + 4'h2); chk(d, 32'h0, "ch2 data");
		rd(REG_CFG0); chk(d, 32'h0, "cfg0 kept");
		cnt_clear();
		cycles(5 * D);
		chk(32'(cnt[2]), 32'h0, "ch2 silent");
		chk(32'(cnt[0]), 32'h5, "ch0 running");
		wr(REG_CFG1, 32'h0);
		rd(REG_STATUS); chk(32'(d[6]), 32'h1, "bias settling");
		// Pulse just after the bias window is only timed, its data is not used
		wait_dr(2, n);
		chk(32'(n >= 2 * D - 4 && n <= 3 * D + 2), 32'h1, "ch2 settle time");
		chk(32'(drdy[0]), 32'h1, "ch2 aligned");
		cycles(B);
		rd(REG_STATUS); chk(32'(d[6]), 32'h0, "bias settled");
		$display("test shutdown done");
		// Every channel in soft reset, then in shutdown
		wr(REG_CFG0, 32'hf);
		chk({core_clk_en, input_clk_en}, 32'h1, "all soft reset gating");
		cnt_clear();
		cycles(4 * D);
		chk({cnt[0], cnt[3]}, 32'h0, "no pulses");
		rd(REG_MODULATOR); chk(d, 32'h3333, "all quantizers");
		wr(REG_CFG0, 32'he);
		chk(32'(core_clk_en), 32'h1, "core back");
		wr(REG_CFG0, 32'h0);
		wr(REG_CFG1, 32'hf);
		chk({core_clk_en, input_clk_en}, 32'h0, "all shut gating");
		wr(REG_CFG1, 32'h7);
		chk({core_clk_en, input_clk_en}, 32'h3, "clocks back");
		$display("test gating done");
		// Clock enable low: a write offered meanwhile is dropped
		@(posedge mclk);
		ce <= 1'b0;
		wr(REG_CFG0, 32'h1);
		@(posedge mclk);
		ce <= 1'b1;
		rd(REG_CFG0); chk(d, 32'h0, "write under ce low");
		$display("test clock enable done");
		// Hard reset in mid-run, with a write offered during it
		wr(REG_CFG0, 32'h5);
		wr(REG_PHASE, 32'h01020304);
		@(posedge mclk);
		rst_n <= 1'b0;
		bus <= '{addr: REG_CFG1, wdata: 32'ha, wr: 1'b1, rd: 1'b0};
		repeat (3) @(posedge mclk);
		bus.wr <= 1'b0;
		rst_n <= 1'b1;
		#1;
		rd(REG_CFG0); chk(d, 32'h0, "cfg0 cleared");
		rd(REG_CFG1); chk(d, 32'h0, "cfg1 cleared");
		rd(REG_PHASE); chk(d, 32'h0, "phase cleared");
		rd(REG_MODULATOR); chk(d, 32'h7f1f, "quantizers live again");
		rd(REG_DATA0); chk(d, 32'h0, "data cleared");
		$display("test hard reset done");
		summarize();
	end

endmodule : tb_acrsc_ctrl
